/* File: core/msc_params.svh */
// Constants for the management interrupt and stop-clock sequencer.
// Assumes inclusion by core files only; definitions only.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_CLK_PERIOD_NS   40
`define MSC_SAVE_CYCLES     4'h4
`define MSC_ACK_MGMT        2'h1
`define MSC_ACK_STOP        2'h2
`define MSC_ACK_NONE        2'h0
`define MSC_SYNC_RESET      1'b1
// Strap counter: loaded in reset, samples once the synchroniser has flushed
`define MSC_STRAP_EDGES     2'h3
`define MSC_STRAP_SAMPLE    2'h1
`endif

/* File: core/msc_pkg.sv */
// Types for the management interrupt and stop-clock sequencer.
// Assumes msc_params.svh is on the include path.
package msc_pkg;
  typedef enum logic [2:0] {
    MSC_RUN,
    MSC_SAVE,
    MSC_MGMT_ACK,
    MSC_MGMT_RUN,
    MSC_GRANT_ACK,
    MSC_GRANT
  } msc_state_t;
endpackage : msc_pkg

/* File: core/msc_sync.sv */
// Two-flop synchroniser for active-low asynchronous request pins.
// Assumes the pin idles high; reset loads the idle level.
`timescale 1ns/1ns
`include "msc_params.svh"
module msc_sync (
  input  wire logic i_core_clk,  // Bus clock
  input  wire logic i_rst_b,     // Async reset, active low
  input  wire logic i_async_n,   // Raw pin
  output logic      o_sync_n     // Synchronised level
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // First flop feeds only the second
  always_comb begin
    meta_next = i_async_n;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= `MSC_SYNC_RESET;
      sync_reg <= `MSC_SYNC_RESET;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync_n = sync_reg;
endmodule : msc_sync

/* File: core/msc_ctrl.sv */
// Management interrupt and stop-clock sequencer of the core.
// Assumes one bus clock; acknowledge cycles are handed to the bus unit.
`timescale 1ns/1ns
`include "msc_params.svh"
module msc_ctrl
  import msc_pkg::*;
#(
  parameter int SAVE_CYCLES = `MSC_SAVE_CYCLES
) (
  input  wire logic       i_core_clk,              // Bus clock, 25 MHz
  input  wire logic       i_rst_b,                 // Async reset, active low
  input  wire logic       i_mgmt_interrupt_req_n,  // Async interrupt request
  input  wire logic       i_stop_clock_req_n,      // Async stop-clock request
  input  wire logic       i_ack_done,              // Bus unit finished ack cycle
  input  wire logic       i_rsm_done,              // Handler returned from mode
  output logic            o_mgmt_exec_mode,        // In management mode
  output logic            o_save_state,            // Execution state save strobe
  output logic            o_ack_req,               // Acknowledge cycle request
  output logic [1:0]      o_ack_type,              // Which acknowledge
  output logic            o_handler_start,         // Handler start pulse
  output logic            o_core_clk_en,           // Core unit clock gate
  output logic            o_bus_snoop_en,          // Bus unit and interrupt ctrl
  output logic            o_output_float           // Float all pin drivers
);
  // Save counter is four bits wide; a longer window needs a wider count
  if (SAVE_CYCLES < 1 || SAVE_CYCLES > 15) begin : g_bad_save
    $error("SAVE_CYCLES must be 1..15");
  end

  localparam logic [3:0] SAVE_LAST = 4'(SAVE_CYCLES - 1);

  logic mint_n;
  logic stop_n;

  // Both pins are asynchronous to the bus clock
  msc_sync u_sync_mint (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async_n  (i_mgmt_interrupt_req_n),
    .o_sync_n   (mint_n)
  );

  msc_sync u_sync_stop (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async_n  (i_stop_clock_req_n),
    .o_sync_n   (stop_n)
  );

  // Registers and their next values, one pair per line
  msc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] strap_reg, strap_next;
  logic       float_reg, float_next;
  logic       snoop_reg, snoop_next;
  logic       mint_prev_reg, mint_prev_next;
  logic       pend_reg, pend_next;
  logic       save_reg, save_next;
  logic       ackreq_reg, ackreq_next;
  logic [1:0] acktype_reg, acktype_next;
  logic       start_reg, start_next;
  logic       mode_reg, mode_next;
  logic       clken_reg, clken_next;

  // Strap sample waits out the synchroniser's reset level: sampled any
  // sooner it would only ever see the idle high that reset leaves
  always_comb begin
    strap_next = strap_reg;
    float_next = float_reg;
    if (strap_reg != 2'h0) begin
      strap_next = strap_reg - 2'h1;
    end
    if (strap_reg == `MSC_STRAP_SAMPLE) begin
      float_next = ~mint_n;
    end
    snoop_next = ~float_next;          // Off only while floating
  end

  // Falling-edge latch of interrupt; set wins over the accept clear
  always_comb begin
    mint_prev_next = mint_n;
    pend_next      = pend_reg;
    if (state_next == MSC_SAVE && state_reg != MSC_SAVE) begin
      pend_next = 1'b0;
    end
    // No edge is taken before the strap sample, so a request held
    // through reset cannot also start a save
    if (mint_prev_reg && !mint_n && strap_reg == 2'h0) begin
      pend_next = 1'b1;
    end
  end

  // Main sequencer; a stop request that arrives with an interrupt wins,
  // since the interrupt needs one more edge to latch as pending
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    save_next    = 1'b0;
    start_next   = 1'b0;
    ackreq_next  = ackreq_reg;
    acktype_next = acktype_reg;
    mode_next    = mode_reg;
    clken_next   = clken_reg;
    case (state_reg)
      MSC_RUN, MSC_MGMT_RUN: begin
        if (float_reg || strap_reg != 2'h0) begin
          state_next = state_reg;      // Frozen until strap, or while floating
        end else if (pend_reg && !mode_reg) begin
          state_next = MSC_SAVE;
          cnt_next   = 4'h0;
          save_next  = 1'b1;
        end else if (!stop_n) begin
          state_next   = MSC_GRANT_ACK;
          ackreq_next  = 1'b1;
          acktype_next = `MSC_ACK_STOP;
        end else if (mode_reg && i_rsm_done) begin
          mode_next  = 1'b0;
          state_next = MSC_RUN;
        end
      end
      MSC_SAVE: begin
        // Count runs up to SAVE_LAST after the single save strobe
        if (cnt_reg == SAVE_LAST) begin
          mode_next    = 1'b1;
          state_next   = MSC_MGMT_ACK;
          ackreq_next  = 1'b1;
          acktype_next = `MSC_ACK_MGMT;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      MSC_MGMT_ACK: begin
        // Handler starts only once the acknowledge has gone out
        if (i_ack_done) begin
          ackreq_next  = 1'b0;
          acktype_next = `MSC_ACK_NONE;
          start_next   = 1'b1;
          state_next   = MSC_MGMT_RUN;
        end
      end
      MSC_GRANT_ACK: begin
        // Core clocks stop only after the grant acknowledge completes
        if (i_ack_done) begin
          ackreq_next  = 1'b0;
          acktype_next = `MSC_ACK_NONE;
          clken_next   = 1'b0;
          state_next   = MSC_GRANT;
        end
      end
      MSC_GRANT: begin
        // Return to whichever mode the grant interrupted
        if (stop_n) begin
          clken_next = 1'b1;
          state_next = mode_reg ? MSC_MGMT_RUN : MSC_RUN;
        end
      end
      default: begin
        state_next = MSC_RUN;
      end
    endcase
  end

  // Single register stage for all sequencer state
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg    <= MSC_RUN;
      cnt_reg      <= 4'h0;
      strap_reg    <= `MSC_STRAP_EDGES;
      float_reg    <= 1'b0;
      snoop_reg    <= 1'b1;
      mint_prev_reg <= 1'b1;
      pend_reg     <= 1'b0;
      save_reg     <= 1'b0;
      ackreq_reg   <= 1'b0;
      acktype_reg  <= `MSC_ACK_NONE;
      start_reg    <= 1'b0;
      mode_reg     <= 1'b0;
      clken_reg    <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      strap_reg    <= strap_next;
      float_reg    <= float_next;
      snoop_reg    <= snoop_next;
      mint_prev_reg <= mint_prev_next;
      pend_reg     <= pend_next;
      save_reg     <= save_next;
      ackreq_reg   <= ackreq_next;
      acktype_reg  <= acktype_next;
      start_reg    <= start_next;
      mode_reg     <= mode_next;
      clken_reg    <= clken_next;
    end
  end

  // Bus unit and interrupt ctrl stay clocked; gate is core only.
  // Every output is a register, so no glitch reaches the pin drivers
  assign o_core_clk_en    = clken_reg;
  assign o_bus_snoop_en   = snoop_reg;
  assign o_mgmt_exec_mode = mode_reg;
  assign o_save_state     = save_reg;
  assign o_ack_req        = ackreq_reg;
  assign o_ack_type       = acktype_reg;
  assign o_handler_start  = start_reg;
  assign o_output_float   = float_reg;
endmodule : msc_ctrl

/* File: tb/msc_ctrl_properties.sv */
// Port checker for the sequencer.
// Assumes one clock domain; bound into every msc_ctrl.
`timescale 1ns/1ns
module msc_ctrl_properties (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic       i_stop_clock_req_n,
  input wire logic       i_ack_done,
  input wire logic       o_mgmt_exec_mode,
  input wire logic       o_save_state,
  input wire logic       o_ack_req,
  input wire logic [1:0] o_ack_type,
  input wire logic       o_handler_start,
  input wire logic       o_core_clk_en,
  input wire logic       o_bus_snoop_en,
  input wire logic       o_output_float
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Mode follows the save only after the save window
  a_save_then_mode: assert property (o_save_state |-> !o_mgmt_exec_mode [*4] ##1
    (o_mgmt_exec_mode && o_ack_req && o_ack_type == 2'h1)) else $error("save order");
  a_ack_then_start: assert property (o_ack_req && i_ack_done && o_ack_type == 2'h1
    |=> !o_ack_req && o_handler_start) else $error("handler start");
  a_start_in_mode: assert property (o_handler_start |-> o_mgmt_exec_mode
    ##1 !o_handler_start) else $error("start pulse");
  a_ack_holds: assert property (o_ack_req && !i_ack_done |=> o_ack_req
    && $stable(o_ack_type)) else $error("ack dropped");
  a_grant_gates: assert property (o_ack_req && o_ack_type == 2'h2 && i_ack_done
    |=> !o_core_clk_en) else $error("clock not gated");
  a_grant_snoops: assert property (!o_core_clk_en && !o_output_float
    |-> o_bus_snoop_en) else $error("snoop off");
  a_grant_cause: assert property ($rose(o_ack_req) && o_ack_type == 2'h2
    |-> $past(i_stop_clock_req_n, 2) == 1'b0) else $error("grant uncaused");
  a_clock_restart: assert property ($rose(i_stop_clock_req_n) && !o_core_clk_en
    && !o_output_float |-> ##[1:4] o_core_clk_en) else $error("no restart");
  a_float_sticky: assert property (o_output_float |-> !o_bus_snoop_en
    ##1 o_output_float) else $error("float lost");
endmodule : msc_ctrl_properties
bind msc_ctrl msc_ctrl_properties u_props (.i_core_clk, .i_rst_b, .i_stop_clock_req_n,
  .i_ack_done, .o_mgmt_exec_mode, .o_save_state, .o_ack_req, .o_ack_type,
  .o_handler_start, .o_core_clk_en, .o_bus_snoop_en, .o_output_float);

/* File: tb/msc_bus_unit.sv */
// Bus-side model that completes acknowledge cycles.
// Assumes a request level held until its done pulse is seen.
`timescale 1ns/1ns
module msc_bus_unit (
  input  wire logic       i_core_clk,  // Bus clock
  input  wire logic       i_rst_b,     // Async reset, active low
  input  wire logic       i_ack_req,   // Acknowledge cycle wanted
  input  wire logic [3:0] i_delay,     // Cycles before completion
  output logic            o_ack_done   // One-cycle completion
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  // Completing agent answers once per request, slow or prompt
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_reg   <= 4'h0;
      busy_reg   <= 1'b0;
      o_ack_done <= 1'b0;
    end else begin
      o_ack_done <= 1'b0;
      if (!i_ack_req) begin
        wait_reg <= 4'h0;
        busy_reg <= 1'b0;
      end else if (!busy_reg && wait_reg >= i_delay) begin
        o_ack_done <= 1'b1;
        busy_reg   <= 1'b1;
      end else if (!busy_reg) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : msc_bus_unit

/* File: tb/msc_ctrl_tb.sv */
// Self-checking bench for the sequencer.
// Assumes msc_bus_unit completes acknowledge cycles.
`timescale 1ns/1ns
module msc_ctrl_tb;
  logic clk, rst_b, mint_n, stp_n, rsm, ack_done, ack_q;
  logic mode, save, ack_req, start, clk_en, snoop, flt;
  logic [1:0] ack_type;
  logic [3:0] dly, st, exp_q[$];
  int mismatches, cmp_count, cyc, seed = 31102;
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  msc_ctrl dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_mgmt_interrupt_req_n(mint_n),
    .i_stop_clock_req_n(stp_n), .i_ack_done(ack_done), .i_rsm_done(rsm),
    .o_mgmt_exec_mode(mode), .o_save_state(save), .o_ack_req(ack_req),
    .o_ack_type(ack_type), .o_handler_start(start), .o_core_clk_en(clk_en),
    .o_bus_snoop_en(snoop), .o_output_float(flt));
  msc_bus_unit u_bus (.i_core_clk(clk), .i_rst_b(rst_b), .i_ack_req(ack_req),
    .i_delay(dly), .o_ack_done(ack_done));
  assign st = {clk_en, !clk_en, mode, !mode};
  task check(input logic [3:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task conclude;
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task wait_st(input int b);
    for (int i = 0; i < 300 && st[b] !== 1'b1; i++) @(posedge clk);
    check(4'(st[b]), 4'h1, "state");
  endtask : wait_st
  task drain;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
    check(4'(exp_q.size()), 4'h0, "drain");
  endtask : drain
  // Oldest note meets each observed event; also the hang limit
  always @(posedge clk) begin
    if (rst_b && (save || start || (ack_req && !ack_q))) begin
      if (exp_q.size() == 0) check(4'hf, 4'he, "event");
      else check(save ? 4'h8 : start ? {mode, 3'h4} : {2'h0, ack_type},
                 exp_q.pop_front(), "event");
    end
    ack_q <= ack_req;
    cyc   <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst_b = 0;
    mint_n = 1;
    stp_n = 1;
    rsm = 0;
    dly = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    // Interrupt alone, stop alone, then both at once; the stop request is
    // taken one edge sooner, so its grant comes ahead of the save
    for (int k = 0; k < 3; k++) begin
      dly <= 4'($unsigned($random(seed)) % 6);
      if (k == 0) begin
        exp_q.push_back(4'h8);
        exp_q.push_back(4'h1);
        exp_q.push_back(4'hc);
      end else begin
        exp_q.push_back(4'h2);
      end
      mint_n <= (k == 1);
      stp_n <= (k == 0);
      repeat (3 + $unsigned($random(seed)) % 4) @(posedge clk);
      mint_n <= 1;
      if (k != 0) begin
        wait_st(2);
        check(4'(snoop), 4'h1, "snoop");
        if (k == 2) begin
          // Interrupt stays pending through the grant, served after it
          exp_q.push_back(4'h8);
          exp_q.push_back(4'h1);
          exp_q.push_back(4'hc);
        end
        stp_n <= 1;
        wait_st(3);
        check(4'(clk_en), 4'h1, "clk_en");
      end
      drain();
      if (k != 1) begin
        rsm <= 1;
        @(posedge clk);
        rsm <= 0;
        wait_st(0);
        check(4'(mode), 4'h0, "mode");
      end
    end
    check(4'({flt, snoop}), 4'h1, "no float");
    // Request held across reset release floats everything
    rst_b <= 0;
    mint_n <= 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    mint_n <= 1;
    stp_n <= 0;
    repeat (12) @(posedge clk);
    check({flt, snoop, ack_req, save}, 4'h8, "float");
    conclude();
  end
endmodule : msc_ctrl_tb
